// File: rtl/jack_detect_pkg.sv
// Constants and register map for the jack insertion detect block
package jack_detect_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [15:0] ADDR_ENABLE = 16'h02d3;
  localparam logic [15:0] ADDR_RAW_STATUS_A = 16'h1886;
  localparam logic [15:0] ADDR_RAW_STATUS_B = 16'h1986;
  localparam logic [15:0] ADDR_DEBOUNCE_SEL = 16'h1a06;
  localparam logic [15:0] ADDR_IRQ_STATUS = 16'h1a10;
  localparam logic [15:0] ADDR_IRQ_MASK = 16'h1a11;
  localparam logic [15:0] ADDR_SLEEP_CTRL = 16'h1a12;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int ENA_ONE_BIT = 0;
  localparam int ENA_TWO_BIT = 1;
  localparam int STS_ONE_BIT = 0;
  localparam int STS_TWO_BIT = 2;
  localparam int DB_ONE_BIT = 0;
  localparam int DB_TWO_BIT = 2;
  // Irq status/mask: bit0 one rise, 1 one fall, 2 two rise, 3 two fall
  localparam int IRQ_WIDTH = 4;

  // ----------------------------------------------------------------
  // Reset values and timing
  // ----------------------------------------------------------------
  localparam logic [15:0] RST_ENABLE = 16'h0000;
  localparam logic [15:0] RST_DEBOUNCE_SEL = 16'h0000;
  localparam logic [3:0] RST_IRQ_MASK = 4'hf;
  localparam int SYS_CLK_HZ = 25000000;
  localparam int SLOW_CLK_HZ = 32768;
  localparam int SLOW_TICK_CYCLES = SYS_CLK_HZ / SLOW_CLK_HZ;
  localparam int DEBOUNCE_TICKS = 4;

endpackage : jack_detect_pkg

// File: rtl/sense_filter_if.sv
// Interface between the detect top and its per-input filter
`timescale 1ns/1ps
`default_nettype none
interface sense_filter_if;
  logic raw_level;
  logic enable;
  logic debounce_on;
  logic level;
  modport top (output raw_level, output enable, output debounce_on, input level);
  modport filt (input raw_level, input enable, input debounce_on, output level);
endinterface : sense_filter_if
`default_nettype wire

// File: rtl/sense_filter.sv
// Per-input debounce filter for one jack sense line
`timescale 1ns/1ps
`default_nettype none
module sense_filter #(
  parameter int TICKS = jack_detect_pkg::DEBOUNCE_TICKS
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Slow clock tick
  input wire logic slow_tick,
  // Connection to top
  sense_filter_if.filt sf
);

  logic [7:0] cnt_ff;
  logic level_ff;

  // ----------------------------------------------------------------
  // Filter
  // ----------------------------------------------------------------
  // Stable-count on slow ticks; bypassed when debounce is off
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_ff <= 8'h00;
      level_ff <= 1'b0;
    end else if (!sf.enable) begin
      cnt_ff <= 8'h00;
      level_ff <= 1'b0; // Disabled input reads not detected
    end else if (!sf.debounce_on) begin
      cnt_ff <= 8'h00;
      level_ff <= sf.raw_level;
    end else if (sf.raw_level == level_ff) begin
      cnt_ff <= 8'h00;
    end else if (slow_tick) begin
      if (cnt_ff == 8'(TICKS - 1)) begin
        cnt_ff <= 8'h00;
        level_ff <= sf.raw_level;
      end else begin
        cnt_ff <= cnt_ff + 8'h01;
      end
    end
  end

  assign sf.level = level_ff;

endmodule : sense_filter
`default_nettype wire

// File: rtl/jack_detect.sv
// Jack insertion detect top: pins, filters, registers and interrupt
//
// Implementation choice: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module jack_detect #(
  parameter int TICK_CYCLES = jack_detect_pkg::SLOW_TICK_CYCLES,
  parameter int DB_TICKS = jack_detect_pkg::DEBOUNCE_TICKS
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // Jack switch pins, low on insertion
  input wire logic jack_switch_pin_one,
  input wire logic jack_switch_pin_two,
  // Register port
  input wire logic [15:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  // Events and detect outputs
  output logic irq,
  output logic wake_req,
  output logic jack_sense_one,
  output logic jack_sense_two
);

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic [1:0] rst_sync_ff;
  logic rst_n;

  // Async assert, sync release through two stages
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rst_sync_ff <= 2'b00;
    end else begin
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_ff[1];

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [1:0] pin_meta_ff;
  logic [1:0] pin_sync_ff;

  // First stage feeds only the second stage
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_meta_ff <= 2'b11;
      pin_sync_ff <= 2'b11;
    end else begin
      pin_meta_ff <= {jack_switch_pin_two, jack_switch_pin_one};
      pin_sync_ff <= pin_meta_ff;
    end
  end

  // ----------------------------------------------------------------
  // Slow clock tick
  // ----------------------------------------------------------------
  logic [15:0] tick_cnt_ff;
  logic slow_tick;
  logic slow_clk_ena_ff;

  // Internal 32 kHz clock made as a tick, gated by its enable bit
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      tick_cnt_ff <= 16'h0000;
    end else if (!slow_clk_ena_ff || tick_cnt_ff == 16'(TICK_CYCLES - 1)) begin
      tick_cnt_ff <= 16'h0000;
    end else begin
      tick_cnt_ff <= tick_cnt_ff + 16'h0001;
    end
  end
  assign slow_tick = slow_clk_ena_ff && tick_cnt_ff == 16'(TICK_CYCLES - 1);

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  logic [1:0] enable_ff;
  logic [1:0] debounce_sel_ff;
  logic sleep_ff;
  logic [3:0] irq_mask_ff;
  logic [3:0] irq_status_ff;

  // Software-written control fields
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      enable_ff <= 2'b00;
      debounce_sel_ff <= 2'b00;
      slow_clk_ena_ff <= 1'b1;
      irq_mask_ff <= jack_detect_pkg::RST_IRQ_MASK;
    end else if (reg_wr) begin
      case (reg_addr)
        jack_detect_pkg::ADDR_ENABLE: begin
          enable_ff <= {reg_wdata[jack_detect_pkg::ENA_TWO_BIT],
                        reg_wdata[jack_detect_pkg::ENA_ONE_BIT]};
        end
        jack_detect_pkg::ADDR_DEBOUNCE_SEL: begin
          debounce_sel_ff <= {reg_wdata[jack_detect_pkg::DB_TWO_BIT],
                              reg_wdata[jack_detect_pkg::DB_ONE_BIT]};
        end
        jack_detect_pkg::ADDR_IRQ_MASK: begin
          irq_mask_ff <= reg_wdata[3:0];
        end
        jack_detect_pkg::ADDR_SLEEP_CTRL: begin
          slow_clk_ena_ff <= reg_wdata[1];
        end
        default: begin
        end
      endcase
    end
  end

  // Sleep flag kept apart so a wake is never lost under a register write
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sleep_ff <= 1'b0;
    end else if (wake_req) begin
      sleep_ff <= 1'b0;
    end else if (reg_wr && reg_addr == jack_detect_pkg::ADDR_SLEEP_CTRL) begin
      sleep_ff <= reg_wdata[0];
    end
  end

  // ----------------------------------------------------------------
  // Filters
  // ----------------------------------------------------------------
  sense_filter_if sf_one();
  sense_filter_if sf_two();

  // Low pin level means jack present
  assign sf_one.raw_level = ~pin_sync_ff[0];
  assign sf_two.raw_level = ~pin_sync_ff[1];
  assign sf_one.enable = enable_ff[0];
  assign sf_two.enable = enable_ff[1];
  // Sleep forces the bypass regardless of the select bits
  assign sf_one.debounce_on = debounce_sel_ff[0] && !sleep_ff;
  assign sf_two.debounce_on = debounce_sel_ff[1] && !sleep_ff;

  sense_filter #(.TICKS(DB_TICKS)) u_filt_one (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .slow_tick(slow_tick),
    .sf(sf_one)
  );

  sense_filter #(.TICKS(DB_TICKS)) u_filt_two (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .slow_tick(slow_tick),
    .sf(sf_two)
  );

  // ----------------------------------------------------------------
  // Edge events and interrupt
  // ----------------------------------------------------------------
  logic [1:0] level_d_ff;
  logic [1:0] levels;
  logic [3:0] events;
  logic clear_wr;

  assign levels = {sf_two.level, sf_one.level};

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      level_d_ff <= 2'b00;
    end else begin
      level_d_ff <= levels;
    end
  end

  // Rise is insertion, fall is removal, per input
  assign events = {level_d_ff[1] & ~levels[1], ~level_d_ff[1] & levels[1],
                   level_d_ff[0] & ~levels[0], ~level_d_ff[0] & levels[0]};
  assign clear_wr = reg_wr && reg_addr == jack_detect_pkg::ADDR_IRQ_STATUS;

  // Sticky bits, write one to clear; a new event beats the clear
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_status_ff <= 4'h0;
    end else begin
      irq_status_ff <= (irq_status_ff & ~(clear_wr ? reg_wdata[3:0] : 4'h0)) | events;
    end
  end

  // Runs without the slow clock, so it works asleep
  assign irq = |(irq_status_ff & irq_mask_ff);
  // Unmasked insertion edges pull the device out of sleep
  assign wake_req = sleep_ff && |(events & irq_mask_ff & 4'h5);

  // Detect signals for the clamp logic
  assign jack_sense_one = sf_one.level;
  assign jack_sense_two = sf_two.level;

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  logic [15:0] status_word;
  logic [15:0] nxt_rdata;

  always_comb begin
    status_word = 16'h0000;
    status_word[jack_detect_pkg::STS_ONE_BIT] = levels[0];
    status_word[jack_detect_pkg::STS_TWO_BIT] = levels[1];
  end

  // Unmapped addresses read zero
  always_comb begin
    nxt_rdata = 16'h0000;
    case (reg_addr)
      jack_detect_pkg::ADDR_ENABLE: begin
        nxt_rdata = {14'h0000, enable_ff};
      end
      jack_detect_pkg::ADDR_RAW_STATUS_A: begin
        nxt_rdata = status_word;
      end
      jack_detect_pkg::ADDR_RAW_STATUS_B: begin
        nxt_rdata = status_word;
      end
      jack_detect_pkg::ADDR_DEBOUNCE_SEL: begin
        nxt_rdata = {13'h0000, debounce_sel_ff[1], 1'b0, debounce_sel_ff[0]};
      end
      jack_detect_pkg::ADDR_IRQ_STATUS: begin
        nxt_rdata = {12'h000, irq_status_ff};
      end
      jack_detect_pkg::ADDR_IRQ_MASK: begin
        nxt_rdata = {12'h000, irq_mask_ff};
      end
      jack_detect_pkg::ADDR_SLEEP_CTRL: begin
        nxt_rdata = {14'h0000, slow_clk_ena_ff, sleep_ff};
      end
      default: begin
        nxt_rdata = 16'h0000;
      end
    endcase
  end

  // Data valid only in the cycle after the read strobe
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      reg_rdata <= nxt_rdata;
    end else begin
      reg_rdata <= 16'h0000;
    end
  end

endmodule : jack_detect
`default_nettype wire

// File: verif/jack_detect_asserts.sv
// Port-level assertions for the jack insertion detect block
`timescale 1ns/1ps
`default_nettype none
module jack_detect_asserts (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // Pins and register port
  input wire logic jack_switch_pin_one,
  input wire logic jack_switch_pin_two,
  input wire logic [15:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  // Events and detect outputs
  input wire logic irq,
  input wire logic wake_req,
  input wire logic jack_sense_one,
  input wire logic jack_sense_two
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  // ----
  // Properties
  // ----
  property p_read_idle;
    !$past(reg_rd) |-> reg_rdata == 16'h0000;
  endproperty
  property p_status_map;
    $past(reg_rd) && $past(reg_addr) == jack_detect_pkg::ADDR_RAW_STATUS_A |->
      reg_rdata == {13'h0000, $past(jack_sense_two), 1'b0, $past(jack_sense_one)};
  endproperty
  // Back-to-back reads of both copies with steady inputs must agree
  property p_copy_match;
    (reg_rd && reg_addr == jack_detect_pkg::ADDR_RAW_STATUS_A ##1 reg_rd &&
      reg_addr == jack_detect_pkg::ADDR_RAW_STATUS_B && $stable(jack_sense_one) &&
      $stable(jack_sense_two)) |=> reg_rdata == $past(reg_rdata);
  endproperty
  // A rise may come only from a low pin, after sync and filter stages
  property p_one_src;
    $rose(jack_sense_one) |-> !$past(jack_switch_pin_one, 3) || !$past(jack_switch_pin_one, 4);
  endproperty
  property p_two_src;
    $rose(jack_sense_two) |-> !$past(jack_switch_pin_two, 3) || !$past(jack_switch_pin_two, 4);
  endproperty
  property p_wake_pulse;
    wake_req |=> !wake_req;
  endproperty
  property p_wake_irq;
    wake_req |-> ##[0:1] (irq && (jack_sense_one || jack_sense_two));
  endproperty
  // Status is sticky: irq only drops after a register write
  property p_irq_sticky;
    $fell(irq) |-> $past(reg_wr);
  endproperty
  property p_reset_quiet;
    $rose(rstn) |-> (!irq && !jack_sense_one && !jack_sense_two)[*2];
  endproperty
  a_read_idle: assert property (p_read_idle) else $error("read data not idle");
  a_status_map: assert property (p_status_map) else $error("status bits wrong");
  a_copy_match: assert property (p_copy_match) else $error("status copies differ");
  a_one_src: assert property (p_one_src) else $error("input one rose without pin");
  a_two_src: assert property (p_two_src) else $error("input two rose without pin");
  a_wake_pulse: assert property (p_wake_pulse) else $error("wake not a pulse");
  a_wake_irq: assert property (p_wake_irq) else $error("wake without irq");
  a_irq_sticky: assert property (p_irq_sticky) else $error("irq dropped alone");
  a_reset_quiet: assert property (p_reset_quiet) else $error("outputs active at reset");
  c_wake: cover property (wake_req);
  c_irq_clear: cover property ($fell(irq));
  c_two_rise: cover property ($rose(jack_sense_two));
endmodule : jack_detect_asserts
`default_nettype wire

// File: verif/jack_switch_model.sv
// Mechanical jack switches: pulled up, shorted low on insertion
`timescale 1ns/1ps
`default_nettype none
module jack_switch_model (
  // Clock for bounce pattern
  input wire logic sys_clk,
  // Plug commands
  input wire logic insert_one,
  input wire logic insert_two,
  input wire logic bounce_one,
  // Switch pins
  output logic pin_one,
  output logic pin_two
);
  logic [2:0] cnt_ff = 3'h0;
  // Bounce flips at any 4-cycle stride, so no tick phase sees it steady
  always @(posedge sys_clk) cnt_ff <= cnt_ff + 3'h1;
  assign pin_one = bounce_one ? (cnt_ff[2] ^ cnt_ff[0]) : ~insert_one;
  assign pin_two = ~insert_two;
endmodule : jack_switch_model
`default_nettype wire

// File: verif/jack_detect_test.sv
// Self-checking bench for the jack insertion detect block
`timescale 1ns/1ps
`default_nettype none
module jack_detect_test;
  typedef struct packed {logic [15:0] a; logic [15:0] d; logic w; logic [15:0] e;} row_s;
  logic sys_clk, rstn, reg_wr, reg_rd, ins_one, ins_two, bnc_one, pin_one, pin_two;
  logic irq, wake_req, sense_one, sense_two;
  logic wake_seen = 1'b0;
  logic [15:0] reg_addr, reg_wdata, reg_rdata;
  int err_count = 0;
  int n_compared = 0;
  int n;
  row_s rows[11];
  // Short counts keep the run brief
  jack_detect #(.TICK_CYCLES(4), .DB_TICKS(2)) u_dut (.sys_clk(sys_clk), .rstn(rstn),
    .jack_switch_pin_one(pin_one), .jack_switch_pin_two(pin_two), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq),
    .wake_req(wake_req), .jack_sense_one(sense_one), .jack_sense_two(sense_two));
  jack_switch_model u_jack (.sys_clk(sys_clk), .insert_one(ins_one), .insert_two(ins_two),
    .bounce_one(bnc_one), .pin_one(pin_one), .pin_two(pin_two));
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  // Wake is a one-cycle pulse, so latch it
  always @(posedge sys_clk) if (wake_req) wake_seen <= 1'b1;
  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic complete_run;
    $display("Compared %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : complete_run
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [15:0] a, input logic [15:0] exp, input string nm);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(negedge sys_clk);
    check(nm, reg_rdata, exp);
  endtask : rd
  task automatic wait_sense(input logic two, input logic lvl, input int lim);
    n = 0;
    while ((two ? sense_two : sense_one) !== lvl && n < lim) begin
      @(posedge sys_clk);
      n++;
    end
    if (n >= lim) begin
      check("sense_wait", 16'h0001, 16'h0000);
      complete_run();
    end
  endtask : wait_sense
  initial begin
    {rstn, reg_wr, reg_rd, ins_one, ins_two, bnc_one} = 6'h00;
    reg_addr = 16'h0000;
    reg_wdata = 16'h0000;
    rows = '{'{jack_detect_pkg::ADDR_ENABLE, 16'h0000, 1'b0, 16'h0000},
      '{jack_detect_pkg::ADDR_DEBOUNCE_SEL, 16'h0000, 1'b0, 16'h0000},
      '{jack_detect_pkg::ADDR_RAW_STATUS_A, 16'h0000, 1'b0, 16'h0000},
      '{jack_detect_pkg::ADDR_RAW_STATUS_B, 16'h0000, 1'b0, 16'h0000},
      '{jack_detect_pkg::ADDR_IRQ_MASK, 16'h0000, 1'b0, 16'h000f},
      '{jack_detect_pkg::ADDR_SLEEP_CTRL, 16'h0000, 1'b0, 16'h0002},
      '{16'h0100, 16'hffff, 1'b1, 16'h0000},
      '{jack_detect_pkg::ADDR_RAW_STATUS_A, 16'hffff, 1'b1, 16'h0000},
      '{jack_detect_pkg::ADDR_DEBOUNCE_SEL, 16'h0005, 1'b1, 16'h0005},
      '{jack_detect_pkg::ADDR_DEBOUNCE_SEL, 16'h0000, 1'b1, 16'h0000},
      '{jack_detect_pkg::ADDR_ENABLE, 16'h0003, 1'b1, 16'h0003}};
    repeat (4) @(posedge sys_clk);
    rstn <= 1'b1;
    repeat (3) @(posedge sys_clk);
    foreach (rows[i]) begin
      if (rows[i].w) wr(rows[i].a, rows[i].d);
      rd(rows[i].a, rows[i].e, "row");
    end
    // Plain insert and removal on input one
    @(posedge sys_clk) ins_one <= 1'b1;
    wait_sense(1'b0, 1'b1, 8);
    // Both copies read back to back, no gap between strobes
    @(posedge sys_clk);
    reg_addr <= jack_detect_pkg::ADDR_RAW_STATUS_A;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_addr <= jack_detect_pkg::ADDR_RAW_STATUS_B;
    @(negedge sys_clk);
    check("copy_a", reg_rdata, 16'h0001);
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(negedge sys_clk);
    check("copy_b", reg_rdata, 16'h0001);
    rd(jack_detect_pkg::ADDR_IRQ_STATUS, 16'h0001, "rise_evt");
    wr(jack_detect_pkg::ADDR_IRQ_STATUS, 16'h0001);
    // Clear lands on the edge the write returns at; look once it has settled
    @(negedge sys_clk);
    check("irq_clr", {15'h0000, irq}, 16'h0000);
    @(posedge sys_clk) ins_one <= 1'b0;
    wait_sense(1'b0, 1'b0, 8);
    rd(jack_detect_pkg::ADDR_IRQ_STATUS, 16'h0002, "fall_evt");
    // Only the fall of input two may interrupt
    wr(jack_detect_pkg::ADDR_IRQ_MASK, 16'h0008);
    wr(jack_detect_pkg::ADDR_IRQ_STATUS, 16'h000f);
    @(posedge sys_clk) ins_two <= 1'b1;
    wait_sense(1'b1, 1'b1, 8);
    rd(jack_detect_pkg::ADDR_RAW_STATUS_B, 16'h0004, "two_sts");
    repeat (2) @(posedge sys_clk);
    check("irq_masked", {15'h0000, irq}, 16'h0000);
    @(posedge sys_clk) ins_two <= 1'b0;
    wait_sense(1'b1, 1'b0, 8);
    repeat (2) @(posedge sys_clk);
    check("irq_fall", {15'h0000, irq}, 16'h0001);
    rd(jack_detect_pkg::ADDR_IRQ_STATUS, 16'h000c, "two_evts");
    wr(jack_detect_pkg::ADDR_IRQ_STATUS, 16'h000f);
    wr(jack_detect_pkg::ADDR_IRQ_MASK, 16'h000f);
    // Bounce is filtered, then a steady insert is taken late
    wr(jack_detect_pkg::ADDR_DEBOUNCE_SEL, 16'h0005);
    @(posedge sys_clk) bnc_one <= 1'b1;
    repeat (40) @(posedge sys_clk);
    check("bounce", {15'h0000, sense_one}, 16'h0000);
    // Let the pin rest high so no count survives from the bounce
    bnc_one <= 1'b0;
    repeat (4) @(posedge sys_clk);
    ins_one <= 1'b1;
    // Two sync stages, then up to four cycles to the next tick and one full tick of four cycles
    wait_sense(1'b0, 1'b1, 60);
    check("db_delay", 16'(n >= 8 && n <= 11), 16'h0001);
    @(posedge sys_clk) ins_one <= 1'b0;
    wait_sense(1'b0, 1'b0, 60);
    wr(jack_detect_pkg::ADDR_IRQ_STATUS, 16'h000f);
    // Sleep: no debounce, insertion wakes the device
    wr(jack_detect_pkg::ADDR_SLEEP_CTRL, 16'h0003);
    @(posedge sys_clk) ins_one <= 1'b1;
    wait_sense(1'b0, 1'b1, 6);
    repeat (2) @(posedge sys_clk);
    check("wake", {15'h0000, wake_seen}, 16'h0001);
    check("irq_sleep", {15'h0000, irq}, 16'h0001);
    rd(jack_detect_pkg::ADDR_SLEEP_CTRL, 16'h0002, "awake");
    // Asleep, a removal still interrupts but does not wake
    wr(jack_detect_pkg::ADDR_IRQ_STATUS, 16'h000f);
    wr(jack_detect_pkg::ADDR_SLEEP_CTRL, 16'h0003);
    @(posedge sys_clk) ins_one <= 1'b0;
    wait_sense(1'b0, 1'b0, 6);
    repeat (2) @(posedge sys_clk);
    check("irq_asleep", {15'h0000, irq}, 16'h0001);
    rd(jack_detect_pkg::ADDR_SLEEP_CTRL, 16'h0003, "still_asleep");
    // Mid-run reset: present jack reads absent while disabled
    @(posedge sys_clk) rstn <= 1'b0;
    ins_one <= 1'b1;
    repeat (4) @(posedge sys_clk);
    rstn <= 1'b1;
    repeat (3) @(posedge sys_clk);
    rd(jack_detect_pkg::ADDR_ENABLE, 16'h0000, "en_rst");
    rd(jack_detect_pkg::ADDR_RAW_STATUS_A, 16'h0000, "disabled");
    complete_run();
  end
endmodule : jack_detect_test
bind jack_detect jack_detect_asserts u_chk (.sys_clk(sys_clk), .rstn(rstn),
  .jack_switch_pin_one(jack_switch_pin_one), .jack_switch_pin_two(jack_switch_pin_two),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .irq(irq), .wake_req(wake_req), .jack_sense_one(jack_sense_one),
  .jack_sense_two(jack_sense_two));
`default_nettype wire
